//--- pkg/clock_timer_standby_cfg.svh
// Constants for the clock, timer and standby controller.
// Assumes inclusion by bare name from the package; the design file uses its macros without including it.
`ifndef CLOCK_TIMER_STANDBY_CFG_SVH
`define CLOCK_TIMER_STANDBY_CFG_SVH

// Internal oscillator half period in fast clock cycles (10 MHz, 100 ns).
`define CLK_PERIOD_NS 100
`define OSC_HALF_NS 800
`define OSC_HALF_CYCLES (`OSC_HALF_NS / `CLK_PERIOD_NS)
`define OSC_CNT_W 4

// Port output pointer values and accumulator bit positions.
`define REQ_ENABLE_PTR 4'hf
`define REQ_ENABLE_BIT 3
`define COUNT_SEL_PTR 4'hb
`define COUNT_SEL_HI_BIT 2
`define COUNT_SEL_LO_BIT 1

// Reset values and the timer maximum.
`define COUNT_SEL_RESET 2'h0
`define TIMER_RESET 8'h00
`define TIMER_MAX 8'hff

// Prescaler terminal values for divide by 256, 32 and 4.
`define PRE_DIV256_MAX 8'hff
`define PRE_DIV32_MAX 5'h1f
`define PRE_DIV4_MAX 2'h3

// Synchroniser input positions.
`define SYNC_OSC 0
`define SYNC_EVENT 1
`define SYNC_RESET 2
`define SYNC_W 3

`endif

//--- pkg/clock_timer_standby_pkg.sv
// Types shared by the clock, timer and standby controller.
// Assumes the constants header is on the include path.
`include "clock_timer_standby_cfg.svh"

package clock_timer_standby_pkg;

    // Count pulse sources selected by the two mode bits.
    typedef enum logic [1:0] {
        SRC_DIV256 = 2'b00,
        SRC_EVENT = 2'b01,
        SRC_DIV32 = 2'b10,
        SRC_DIV4 = 2'b11
    } count_src_type;

endpackage

//--- src/clock_timer_standby_ctrl.sv
// Clock generation, standby flip-flops, count source selection, 8-bit
// timer/event counter and the two test request flags.
// Assumes the CPU issues one-cycle instruction strobes on clk and that the
// pins come from outside the clk domain.
`timescale 1ns/1ps
`default_nettype none

module clock_timer_standby_ctrl
    import clock_timer_standby_pkg::*;
(
    input wire logic clk, // Fast sampling clock, 10 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic ceramic_strap, // High selects ceramic variant, taken after reset.
    input wire logic ext_clk_sel, // RC variant: high takes external clock.
    input wire logic osc_in_pin, // Oscillator input or external clock pin.
    input wire logic event_input_pin, // Event and external request pin.
    input wire logic reset_pin, // Device reset pin, active high.
    input wire logic stop_instr, // Stop instruction strobe.
    input wire logic halt_instr, // Halt instruction strobe.
    input wire logic timer_instr, // Timer clear instruction strobe.
    input wire logic skip_on_flag_instr, // Skip-on-flag instruction strobe.
    input wire logic skip_sel_ext, // Skip target: 1 external flag, 0 timer flag.
    input wire logic port_out_instr, // Port output instruction strobe.
    input wire logic [3:0] port_ptr, // Pointer value of the port output.
    input wire logic [3:0] acc, // Accumulator value of the port output.
    output logic osc_out_pin, // Inverted oscillator output pin.
    output logic sys_clk, // System clock level.
    output logic cpu_clk, // CPU clock level.
    output logic cpu_tick, // One-cycle pulse per CPU clock period.
    output logic stop_mode, // Stop flip-flop.
    output logic halt_mode, // Halt flip-flop.
    output logic [1:0] count_source_select, // Count source mode bits.
    output logic [7:0] timer_count, // Timer/event counter value.
    output logic timer_req_flag, // Timer overflow request flag.
    output logic ext_req_flag, // External request flag.
    output logic ext_req_enable, // External request enable bit.
    output logic skip_result // Flag value seen by the last skip instruction.
);

    logic [`SYNC_W-1:0] sync1;
    logic [`SYNC_W-1:0] sync2;
    logic [`SYNC_W-1:0] sync3;
    logic [`SYNC_W-1:0] pin_level;
    logic [`SYNC_W-1:0] pin_rise;
    logic [`SYNC_W-1:0] pin_fall;
    logic strap_taken;
    logic ceramic;
    logic rst_level;
    logic rst_fall;
    logic [`OSC_CNT_W-1:0] osc_cnt;
    logic sys_prev;
    logic sys_rise;
    logic [7:0] prescale;
    logic count_pulse;
    logic any_flag;
    logic count_sel_lo;
    logic count_sel_hi;
    count_src_type src;

    // Pins pass three flops; a change counts once the second and third agree.
    generate
        for (genvar i = 0; i < `SYNC_W; i++) begin : g_sync
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                    sync3[i] <= 1'b0;
                    pin_level[i] <= 1'b0;
                end else begin
                    sync1[i] <= (i == `SYNC_OSC) ? osc_in_pin :
                                (i == `SYNC_EVENT) ? event_input_pin : reset_pin;
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    if (sync2[i] == sync3[i]) begin
                        pin_level[i] <= sync3[i];
                    end
                end
            end
            assign pin_rise[i] = (sync2[i] == sync3[i]) && sync3[i] && !pin_level[i];
            assign pin_fall[i] = (sync2[i] == sync3[i]) && !sync3[i] && pin_level[i];
        end
    endgenerate

    assign rst_level = pin_level[`SYNC_RESET];
    assign rst_fall = pin_fall[`SYNC_RESET];
    assign any_flag = timer_req_flag || ext_req_flag;
    assign count_sel_lo = count_source_select[0];
    assign count_sel_hi = count_source_select[1];
    assign src = count_src_type'({count_sel_hi, count_sel_lo});

    // The variant strap is caught by a clocked process after reset release.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_taken <= 1'b0;
            ceramic <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            ceramic <= ceramic_strap;
        end
    end

    // Oscillator: an internal half-period counter, or the external clock on
    // the RC variant. It freezes while the stop flip-flop is set.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt <= '0;
            sys_clk <= 1'b0;
        end else if (stop_mode) begin
            osc_cnt <= '0;
        end else if (!ceramic && ext_clk_sel) begin
            sys_clk <= pin_level[`SYNC_OSC];
        end else if (osc_cnt == `OSC_CNT_W'(`OSC_HALF_CYCLES - 1)) begin
            osc_cnt <= '0;
            sys_clk <= !sys_clk;
        end else begin
            osc_cnt <= osc_cnt + `OSC_CNT_W'(1);
        end
    end

    // The output pin is the inverted oscillator, as in buffer mode.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_out_pin <= 1'b1;
            sys_prev <= 1'b0;
        end else begin
            osc_out_pin <= !sys_clk;
            sys_prev <= sys_clk;
        end
    end

    // Ceramic reset keeps the oscillator running but withholds its supply so
    // an unsettled clock never reaches the logic.
    assign sys_rise = sys_clk && !sys_prev && !(ceramic && rst_level);

    // Divide by two, fed only while halt is clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_clk <= 1'b0;
            cpu_tick <= 1'b0;
        end else begin
            cpu_tick <= sys_rise && !halt_mode && cpu_clk;
            if (sys_rise && !halt_mode) begin
                cpu_clk <= !cpu_clk;
            end
        end
    end

    // Stop flip-flop. Entry is refused while any request flag is set.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_mode <= 1'b0;
        end else if (ceramic && rst_level) begin
            stop_mode <= 1'b0;
        end else if (!ceramic && (any_flag || rst_fall)) begin
            stop_mode <= 1'b0;
        end else if (stop_instr && !any_flag) begin
            stop_mode <= 1'b1;
        end
    end

    // Halt flip-flop. Ceramic reset holds it set; the reset fall itself releases it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            halt_mode <= 1'b0;
        end else if (ceramic && rst_level && !rst_fall) begin
            halt_mode <= 1'b1;
        end else if (any_flag || rst_fall) begin
            halt_mode <= 1'b0;
        end else if (halt_instr && !any_flag) begin
            halt_mode <= 1'b1;
        end
    end

    // Prescaler runs on the supplied system clock, so it stops with stop.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale <= 8'h00;
        end else if (rst_level) begin
            prescale <= 8'h00;
        end else if (sys_rise) begin
            prescale <= prescale + 8'h01;
        end
    end

    // Count pulse multiplexer. The event pin keeps counting during stop.
    always_comb begin
        case (src)
            SRC_DIV256: count_pulse = sys_rise && (prescale == `PRE_DIV256_MAX);
            SRC_EVENT: count_pulse = pin_rise[`SYNC_EVENT];
            SRC_DIV32: count_pulse = sys_rise && (prescale[4:0] == `PRE_DIV32_MAX);
            SRC_DIV4: count_pulse = sys_rise && (prescale[1:0] == `PRE_DIV4_MAX);
            default: count_pulse = 1'b0;
        endcase
    end

    // Mode bits and request enable, written by the port output instruction.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_source_select <= `COUNT_SEL_RESET;
            ext_req_enable <= 1'b0;
        end else if (rst_level) begin
            count_source_select <= `COUNT_SEL_RESET;
            ext_req_enable <= 1'b0;
        end else if (port_out_instr && port_ptr == `REQ_ENABLE_PTR) begin
            ext_req_enable <= acc[`REQ_ENABLE_BIT];
        end else if (port_out_instr && port_ptr == `COUNT_SEL_PTR) begin
            count_source_select <= {acc[`COUNT_SEL_HI_BIT], acc[`COUNT_SEL_LO_BIT]};
        end
    end

    // Timer/event counter; it wraps from its maximum to zero by itself.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_count <= `TIMER_RESET;
        end else if (rst_level || timer_instr) begin
            timer_count <= `TIMER_RESET;
        end else if (count_pulse) begin
            timer_count <= timer_count + 8'h01;
        end
    end

    // Request flags: a set arriving with a software clear still wins.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_req_flag <= 1'b0;
            ext_req_flag <= 1'b0;
        end else if (rst_level) begin
            timer_req_flag <= 1'b0;
            ext_req_flag <= 1'b0;
        end else begin
            if (count_pulse && timer_count == `TIMER_MAX) begin
                timer_req_flag <= 1'b1;
            end else if (timer_instr || (skip_on_flag_instr && !skip_sel_ext)) begin
                timer_req_flag <= 1'b0;
            end
            if (pin_rise[`SYNC_EVENT] && ext_req_enable) begin
                ext_req_flag <= 1'b1;
            end else if (skip_on_flag_instr && skip_sel_ext) begin
                ext_req_flag <= 1'b0;
            end
        end
    end

    // Skip decision is taken from the flag value before it is cleared.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            skip_result <= 1'b0;
        end else if (skip_on_flag_instr) begin
            skip_result <= skip_sel_ext ? ext_req_flag : timer_req_flag;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_stop_cmd;
        stop_instr && !any_flag && !rst_level && !rst_fall;
    endsequence
    sequence s_halt_cmd;
        halt_instr && !any_flag && !rst_level && !rst_fall;
    endsequence
    sequence s_stopped_settled;
        stop_mode ##1 stop_mode ##1 stop_mode;
    endsequence
    property p_cpu_div;
        $changed(cpu_clk) |-> $past(sys_rise) && !$past(halt_mode);
    endproperty
    a_cpu_div: assert property (p_cpu_div) else $error("CPU clock moved without a system edge");
    property p_stop_enter;
        s_stop_cmd |=> stop_mode;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("Stop was not entered");
    // The reset pin may still clear the prescaler while stop holds.
    property p_stop_frozen;
        s_stopped_settled |-> !sys_rise && ($stable(prescale) || $past(rst_level));
    endproperty
    a_stop_frozen: assert property (p_stop_frozen) else $error("Clock ran during stop");
    property p_rc_release;
        !ceramic && any_flag |=> !stop_mode && !halt_mode;
    endproperty
    a_rc_release: assert property (p_rc_release) else $error("RC standby not released");
    property p_cer_hold;
        ceramic && rst_level && !rst_fall |=> halt_mode && !stop_mode && !cpu_tick;
    endproperty
    a_cer_hold: assert property (p_cer_hold) else $error("Ceramic reset hold broken");
    property p_halt_enter;
        s_halt_cmd |=> halt_mode;
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("Halt was not entered");
    property p_no_entry;
        any_flag && !stop_mode && !halt_mode |=> !stop_mode && !halt_mode;
    endproperty
    a_no_entry: assert property (p_no_entry) else $error("Standby entered with a flag set");
    property p_timer_inc;
        count_pulse && !timer_instr && !rst_level |=> timer_count == $past(timer_count) + 8'h01;
    endproperty
    a_timer_inc: assert property (p_timer_inc) else $error("Timer did not step by one");
    property p_timer_clr;
        timer_instr |=> timer_count == `TIMER_RESET && (!timer_req_flag || $past(count_pulse));
    endproperty
    a_timer_clr: assert property (p_timer_clr) else $error("Timer instruction did not clear");
    property p_overflow;
        count_pulse && timer_count == `TIMER_MAX && !rst_level |=> timer_req_flag;
    endproperty
    a_overflow: assert property (p_overflow) else $error("Overflow did not set flag");
    property p_ext_gate;
        $rose(ext_req_flag) |-> $past(ext_req_enable) && $past(pin_rise[`SYNC_EVENT]);
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("External flag set while disabled");
    property p_reset_clear;
        rst_level |=> !timer_req_flag && !ext_req_flag && !ext_req_enable;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Reset left a flag set");

endmodule

`default_nettype wire

//--- test/clock_env_model.sv
// Model of what lies beyond the controller's pins: external clock, event line, reset line.
// Assumes the bench clock paces every pin change and the bench calls the tasks.
`timescale 1ns/1ps
`default_nettype none
module clock_env_model (
    input wire logic clk, // Bench clock.
    input wire logic ext_run, // High lets the external clock run.
    output logic osc_in_pin = 1'b0, // External clock pin.
    output logic event_input_pin = 1'b0, // Event and request line.
    output logic reset_pin = 1'b0 // Device reset line, active high.
);
    int ph = 0;

    // External clock of 20 bench cycles; it rests low when unused so no stale edge leaks in.
    always @(posedge clk) begin
        ph <= (ph == 9) ? 0 : ph + 1;
        if (!ext_run) begin
            osc_in_pin <= 1'b0;
        end else if (ph == 9) begin
            osc_in_pin <= ~osc_in_pin;
        end
    end

    // Each event is high and low for four cycles, twice the shortest width the pin accepts.
    task automatic events(input int n);
        repeat (n) begin
            @(posedge clk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge clk);
            event_input_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        #1;
    endtask

    // Moves the reset line; the caller decides how long it stays high.
    task automatic set_reset(input logic lvl);
        @(posedge clk);
        reset_pin <= lvl;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

//--- test/clock_timer_standby_ctrl_tb.sv
// Self-checking bench for the clock, timer and standby controller.
// Assumes the package is compiled first and the pin model sits in its own file.
`timescale 1ns/1ps
`default_nettype none
module clock_timer_standby_ctrl_tb
    import clock_timer_standby_pkg::*;
;
    localparam logic [5:0] ST = 6'h20, HA = 6'h10, TI = 6'h08, SK = 6'h04, PO = 6'h02, SEL = 6'h01;
    logic clk, reset_n, ceramic_strap, ext_clk_sel, ext_run;
    logic stop_instr, halt_instr, timer_instr, skip_on_flag_instr;
    logic port_out_instr, skip_sel_ext;
    logic [3:0] port_ptr, acc;
    wire logic osc_in_pin, event_input_pin, reset_pin;
    logic osc_out_pin, sys_clk, cpu_clk, cpu_tick, stop_mode, halt_mode;
    logic timer_req_flag, ext_req_flag, ext_req_enable, skip_result;
    logic [1:0] count_source_select;
    logic [7:0] timer_count;
    int num_errors = 0, compares = 0, ns, nc, nt;

    // Bench clock at 10 MHz.
    always #50 clk = ~clk;

    clock_timer_standby_ctrl clock_timer_standby_ctrl_inst (.clk(clk), .reset_n(reset_n),
        .ceramic_strap(ceramic_strap), .ext_clk_sel(ext_clk_sel), .osc_in_pin(osc_in_pin),
        .event_input_pin(event_input_pin), .reset_pin(reset_pin), .stop_instr(stop_instr),
        .halt_instr(halt_instr), .timer_instr(timer_instr),
        .skip_on_flag_instr(skip_on_flag_instr), .skip_sel_ext(skip_sel_ext),
        .port_out_instr(port_out_instr), .port_ptr(port_ptr), .acc(acc),
        .osc_out_pin(osc_out_pin), .sys_clk(sys_clk), .cpu_clk(cpu_clk), .cpu_tick(cpu_tick),
        .stop_mode(stop_mode), .halt_mode(halt_mode), .count_source_select(count_source_select),
        .timer_count(timer_count), .timer_req_flag(timer_req_flag), .ext_req_flag(ext_req_flag),
        .ext_req_enable(ext_req_enable), .skip_result(skip_result));

    clock_env_model clock_env_model_inst (.clk(clk), .ext_run(ext_run), .osc_in_pin(osc_in_pin),
        .event_input_pin(event_input_pin), .reset_pin(reset_pin));

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // One instruction strobe; the result is sampled a cycle after the edge that takes it.
    task automatic op(input logic [5:0] s, input logic [3:0] p, input logic [3:0] a);
        @(posedge clk);
        stop_instr <= s[5];
        halt_instr <= s[4];
        timer_instr <= s[3];
        skip_on_flag_instr <= s[2];
        port_out_instr <= s[1];
        skip_sel_ext <= s[0];
        port_ptr <= p;
        acc <= a;
        @(posedge clk);
        stop_instr <= 1'b0;
        halt_instr <= 1'b0;
        timer_instr <= 1'b0;
        skip_on_flag_instr <= 1'b0;
        port_out_instr <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Counts rising edges of the system and CPU clocks over n bench cycles.
    task automatic edges(input int n);
        logic ps, pc;
        ns = 0;
        nc = 0;
        nt = 0;
        ps = sys_clk;
        pc = cpu_clk;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (sys_clk && !ps) ns++;
            if (cpu_clk && !pc) nc++;
            if (cpu_tick) nt++;
            ps = sys_clk;
            pc = cpu_clk;
        end
    endtask

    // Bit 0 of the accumulator is kept clear when the mode bits are written.
    task automatic t_mode(input count_src_type m, input int n, input int lo, input int hi);
        op(PO, 4'hb, {1'b0, m, 1'b0});
        chk("count_source_select", {6'h00, m}, {6'h00, count_source_select});
        op(TI, 4'h0, 4'h0);
        repeat (n) @(posedge clk);
        #1;
        chk("timer_in_range", 8'h01, {7'h00, timer_count >= lo && timer_count <= hi});
    endtask

    task automatic t_basic;
        chk("timer_count", 8'h00, timer_count);
        chk("flags_enable", 8'h00, {timer_req_flag, ext_req_flag, ext_req_enable});
        chk("osc_out_pin", 8'h01, osc_out_pin);
        edges(320);
        chk("sys_rises", 8'h01, {7'h00, ns >= 19 && ns <= 21});
        chk("cpu_half_rate", 8'h01, {7'h00, nc * 2 >= ns - 2 && nc * 2 <= ns + 2});
        chk("cpu_ticks", 8'h01, {7'h00, nt >= nc - 1 && nt <= nc + 1});
        t_mode(SRC_DIV4, 640, 9, 11);
        t_mode(SRC_DIV32, 1024, 1, 3);
        t_mode(SRC_DIV256, 4200, 1, 2);
    endtask

    // Event counting through overflow, with both standby entries refused while a flag is up.
    task automatic t_overflow;
        op(PO, 4'hb, {1'b0, SRC_EVENT, 1'b0});
        op(TI, 4'h0, 4'h0);
        clock_env_model_inst.events(5);
        chk("timer_count", 8'h05, timer_count);
        clock_env_model_inst.events(251);
        chk("timer_count", 8'h00, timer_count);
        chk("timer_req_flag", 8'h01, timer_req_flag);
        chk("ext_req_flag", 8'h00, ext_req_flag);
        op(ST, 4'h0, 4'h0);
        op(HA, 4'h0, 4'h0);
        chk("standby", 8'h00, {stop_mode, halt_mode});
        op(SK, 4'h0, 4'h0);
        chk("skip_result", 8'h01, {timer_req_flag, skip_result});
        clock_env_model_inst.events(256);
        chk("timer_req_flag", 8'h01, timer_req_flag);
        op(TI, 4'h0, 4'h0);
        chk("flag_count", 8'h00, {timer_req_flag, timer_count[6:0]});
        op(PO, 4'hf, 4'h8);
        chk("ext_req_enable", 8'h01, ext_req_enable);
        clock_env_model_inst.events(1);
        chk("ext_req_flag", 8'h01, ext_req_flag);
        op(SK | SEL, 4'h0, 4'h0);
        chk("skip_ext", 8'h01, {ext_req_flag, skip_result});
        op(SK | SEL, 4'h0, 4'h0);
        chk("skip_ext_clear", 8'h00, skip_result);
    endtask

    // Halt keeps the system clock and timer running; a request flag ends it.
    task automatic t_halt;
        op(PO, 4'hb, {1'b0, SRC_DIV4, 1'b0});
        op(TI, 4'h0, 4'h0);
        op(HA, 4'h0, 4'h0);
        chk("halt_mode", 8'h01, halt_mode);
        edges(320);
        chk("halt_clocks", 8'h01, {7'h00, nc == 0 && nt == 0 && ns >= 19});
        chk("timer_in_halt", 8'h01, {7'h00, timer_count >= 4});
        clock_env_model_inst.events(1);
        chk("halt_release", 8'h01, {halt_mode, ext_req_flag});
        op(SK | SEL, 4'h0, 4'h0);
    endtask

    // Stop on the RC variant: events still count, reset fall and a request flag release it.
    task automatic t_stop;
        op(PO, 4'hf, 4'h0);
        op(PO, 4'hb, {1'b0, SRC_EVENT, 1'b0});
        op(TI, 4'h0, 4'h0);
        op(ST, 4'h0, 4'h0);
        edges(160);
        chk("stop_clocks", 8'h81, {stop_mode, 7'h00} | {7'h00, ns == 0 && nc == 0});
        clock_env_model_inst.events(3);
        chk("count_stop", 8'h83, {stop_mode, timer_count[6:0]});
        clock_env_model_inst.set_reset(1'b1);
        repeat (40) @(posedge clk);
        clock_env_model_inst.set_reset(1'b0);
        chk("standby_after_reset", 8'h00, {stop_mode, halt_mode});
        chk("cleared_by_reset", 8'h00, {count_source_select, timer_count[3:0]});
        op(PO, 4'hf, 4'h8);
        op(ST, 4'h0, 4'h0);
        chk("stop_mode", 8'h01, stop_mode);
        clock_env_model_inst.events(1);
        chk("stop_release", 8'h01, {stop_mode, ext_req_flag});
        edges(160);
        chk("sys_restart", 8'h01, {7'h00, ns >= 9});
        op(SK | SEL, 4'h0, 4'h0);
        @(posedge clk);
        ext_clk_sel <= 1'b1;
        ext_run <= 1'b1;
        edges(400);
        chk("ext_clock_rises", 8'h01, {7'h00, ns >= 19 && ns <= 21});
        @(posedge clk);
        ext_clk_sel <= 1'b0;
        ext_run <= 1'b0;
    endtask

    // Ceramic variant: only the reset pin ends stop, and halt holds while it is high.
    task automatic t_ceramic;
        @(posedge clk);
        reset_n <= 1'b0;
        ceramic_strap <= 1'b1;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        op(PO, 4'hf, 4'h8);
        op(ST, 4'h0, 4'h0);
        clock_env_model_inst.events(1);
        chk("ceramic_stop_held", 8'h01, stop_mode);
        clock_env_model_inst.set_reset(1'b1);
        repeat (40) @(posedge clk);
        #1;
        chk("reset_high", 8'h01, {stop_mode, halt_mode});
        clock_env_model_inst.set_reset(1'b0);
        chk("halt_mode", 8'h00, halt_mode);
        edges(160);
        chk("cpu_resumed", 8'h01, {7'h00, nc >= 4 && nt >= 4});
    endtask

    // Main sequence. Every input starts idle before the first clock edge.
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        ceramic_strap = 1'b0;
        ext_clk_sel = 1'b0;
        ext_run = 1'b0;
        stop_instr = 1'b0;
        halt_instr = 1'b0;
        timer_instr = 1'b0;
        skip_on_flag_instr = 1'b0;
        port_out_instr = 1'b0;
        skip_sel_ext = 1'b0;
        port_ptr = 4'h0;
        acc = 4'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_basic;
        t_overflow;
        t_halt;
        t_stop;
        t_ceramic;
        stop_test;
    end

    // Watchdog well beyond the expected run of about 1.2 ms.
    initial begin
        #6_000_000;
        num_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
